// >>> verilog/rsq_pkg.sv
// rsq_pkg: constants and carriers of the repeated start sequencer
// assumes: 32-bit Avalon-MM slave with byte addresses, open-drain pads
package rsq_pkg;

    localparam int ADDR_W   = 4;
    localparam int WORD_LSB = 2;
    localparam int BAUD_W   = 7;
    localparam int LOAD_W   = 6;
    localparam int LOW_W    = 5;
    localparam int BYTE_W   = 8;

    localparam logic [ADDR_W-1:0] OFS_CTRL2 = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STAT  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_BAUD  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_SBUF  = 4'hc;

    localparam int CTRL2_RESTART = 1;

    localparam int ST_EVENT = 0;
    localparam int ST_WRITE_COLLISION_FLAG  = 1;
    localparam int ST_BCOL  = 2;
    localparam int ST_START = 3;
    localparam int ST_BUSY  = 4;

    localparam int TG_DONE  = 0;
    localparam int TG_COLL  = 1;
    localparam int TG_START = 2;
    localparam int TG_N     = 3;

    localparam logic [BAUD_W-1:0] BAUD_RST = 7'h04;
    localparam logic [BAUD_W-1:0] CNT_ONE  = 7'h01;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [31:0]       WORD_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_SCL_LOW   = 3'b001,
        ST_SDA_REL   = 3'b010,
        ST_SCL_REL   = 3'b011,
        ST_HIGH_WAIT = 3'b100,
        ST_SDA_LOW   = 3'b101
    } rsq_state_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } rsq_av_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } rsq_av_rsp_t;

    typedef struct packed {
        logic sda;
        logic scl;
    } rsq_pin_in_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
        logic scl_o;
        logic scl_oe;
    } rsq_pin_out_t;

endpackage

// >>> verilog/rsq_top.sv
// rsq_top: repeated start sequencer with bus collision detection
// assumes: registers on sys_clk over Avalon-MM, pins on free link_clk,
// pads outside resolve open-drain lines from the enables
// Contract
// - start only on request while idle
// - pull SCL low, then load low six bits
// - release SDA for one baud period
// - on expiry with SDA high, release SCL
// - SCL high reloads full seven-bit value
// - then drive SDA low one period
// - finish clears request, no reload, SDA low
// - start condition on pins sets start flag
// - event flag only after counter expiry; code also sets it on every collision
// - request during other bus event ignored
// - buffer write during restart sets collision flag
// - low five control bits locked while busy
// - SDA low as SCL rises is collision
// - SCL falling before SDA driven is collision
// - SDA falling early is no collision
// - count to zero, release SCL, sample SDA
// - both high: drive SDA, reload, then SCL
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
module rsq_top
    import rsq_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  link_clk,
    input  wire rsq_pkg::rsq_av_req_t  av_req,
    output      rsq_pkg::rsq_av_rsp_t  av_rsp,
    input  wire logic                  other_event_busy,
    input  wire rsq_pkg::rsq_pin_in_t  pin_in,
    output      rsq_pkg::rsq_pin_out_t pin_out
);

    import rsq_pkg::*;

    typedef struct packed {
        logic              wreq;
        logic [31:0]       rdata;
        logic [BYTE_W-1:0] ctrl2;
        logic [BAUD_W-1:0] baud;
        logic [BYTE_W-1:0] sbuf;
        logic              ev;
        logic              write_collision_flag;
        logic              bcol;
        logic              start;
        logic              busy;
        logic              req_tgl;
        logic [TG_N-1:0]   tg_s1;
        logic [TG_N-1:0]   tg_s2;
        logic [TG_N-1:0]   tg_s3;
    } rsq_sys_t;

    typedef struct packed {
        logic              rst_s1;
        logic              rst_s2;
        logic              req_s1;
        logic              req_s2;
        logic              req_s3;
        logic              sda_s1;
        logic              sda_s2;
        logic              sda_s3;
        logic              scl_s1;
        logic              scl_s2;
        rsq_state_t        st;
        logic [BAUD_W-1:0] cnt;
        logic [BAUD_W-1:0] reload;
        logic              sda_drv;
        logic              scl_drv;
        logic [TG_N-1:0]   tg;
        logic              lo;
    } rsq_link_t;

    rsq_sys_t          s_reg;
    rsq_sys_t          s_next;
    rsq_link_t         l_reg;
    rsq_link_t         l_next;
    logic [TG_N-1:0]   ev_tg;
    logic              wr_acc;
    logic              done_or_coll;
    logic [31:0]       rd_word;
    logic [ST_START:0] flag_clr;
    logic              cnt_zero;

    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs
    );
        hit = (a[ADDR_W-1:WORD_LSB] == ofs[ADDR_W-1:WORD_LSB]);
    endfunction

    // abandon the sequence, free both lines, stop counting
    function automatic rsq_link_t collide(input rsq_link_t v);
        rsq_link_t r;
        r             = v;
        r.sda_drv     = 1'b0;
        r.scl_drv     = 1'b0;
        r.cnt         = '0;
        r.st          = ST_IDLE;
        r.tg[TG_COLL] = ~v.tg[TG_COLL];
        collide       = r;
    endfunction

    // ---------------- system clock side ----------------

    always_comb begin
        rd_word = WORD_ZERO;
        if (hit(av_req.address, OFS_CTRL2)) begin
            rd_word[BYTE_W-1:0] = s_reg.ctrl2;
        end
        if (hit(av_req.address, OFS_STAT)) begin
            rd_word[ST_EVENT] = s_reg.ev;
            rd_word[ST_WRITE_COLLISION_FLAG]  = s_reg.write_collision_flag;
            rd_word[ST_BCOL]  = s_reg.bcol;
            rd_word[ST_START] = s_reg.start;
            rd_word[ST_BUSY]  = s_reg.busy;
        end
        if (hit(av_req.address, OFS_BAUD)) begin
            rd_word[BAUD_W-1:0] = s_reg.baud;
        end
        if (hit(av_req.address, OFS_SBUF)) begin
            rd_word[BYTE_W-1:0] = s_reg.sbuf;
        end
    end

    always_comb begin
        s_next       = s_reg;
        s_next.tg_s1 = l_reg.tg;
        s_next.tg_s2 = s_reg.tg_s1;
        s_next.tg_s3 = s_reg.tg_s2;
        ev_tg        = s_reg.tg_s2 ^ s_reg.tg_s3;
        done_or_coll = ev_tg[TG_DONE] | ev_tg[TG_COLL];
        wr_acc       = av_req.write && !s_reg.wreq
                       && av_req.byteenable[0];
        flag_clr     = '0;

        // answer one cycle after the request is seen
        s_next.wreq = 1'b1;
        if ((av_req.read || av_req.write) && s_reg.wreq) begin
            s_next.wreq  = 1'b0;
            s_next.rdata = av_req.read ? rd_word : WORD_ZERO;
        end

        if (wr_acc && hit(av_req.address, OFS_STAT)) begin
            flag_clr = av_req.writedata[ST_START:0];
        end

        if (wr_acc && hit(av_req.address, OFS_CTRL2)) begin
            s_next.ctrl2[BYTE_W-1:LOW_W] =
                av_req.writedata[BYTE_W-1:LOW_W];
            if (!s_reg.busy) begin
                s_next.ctrl2[LOW_W-1:0] =
                    av_req.writedata[LOW_W-1:0];
                s_next.ctrl2[CTRL2_RESTART] = 1'b0;
                if (av_req.writedata[CTRL2_RESTART]
                    && !other_event_busy) begin
                    s_next.ctrl2[CTRL2_RESTART] = 1'b1;
                    s_next.busy    = 1'b1;
                    s_next.req_tgl = ~s_reg.req_tgl;
                end
            end
        end

        if (wr_acc && hit(av_req.address, OFS_BAUD)
            && !s_reg.busy) begin
            s_next.baud = av_req.writedata[BAUD_W-1:0];
        end

        // clears first, so a set in the same cycle wins
        s_next.ev    = s_reg.ev    & ~flag_clr[ST_EVENT];
        s_next.write_collision_flag  = s_reg.write_collision_flag  & ~flag_clr[ST_WRITE_COLLISION_FLAG];
        s_next.bcol  = s_reg.bcol  & ~flag_clr[ST_BCOL];
        s_next.start = s_reg.start & ~flag_clr[ST_START];

        if (wr_acc && hit(av_req.address, OFS_SBUF)) begin
            if (s_reg.busy) begin
                s_next.write_collision_flag = 1'b1;
            end else begin
                s_next.sbuf = av_req.writedata[BYTE_W-1:0];
            end
        end

        if (done_or_coll) begin
            s_next.busy = 1'b0;
            s_next.ctrl2[CTRL2_RESTART] = 1'b0;
            s_next.ev   = 1'b1;
        end
        if (ev_tg[TG_COLL]) begin
            s_next.bcol = 1'b1;
        end
        if (ev_tg[TG_START]) begin
            s_next.start = 1'b1;
        end

        if (!resetn) begin
            s_next      = '0;
            s_next.wreq = 1'b1;
            s_next.baud = BAUD_RST;
            s_next.sbuf = BYTE_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        s_reg <= s_next;
    end

    assign av_rsp = '{waitrequest: s_reg.wreq,
                      readdata:    s_reg.rdata};

    // ---------------- link clock side ----------------

    always_comb begin
        l_next        = l_reg;
        l_next.rst_s1 = resetn;
        l_next.rst_s2 = l_reg.rst_s1;
        l_next.req_s1 = s_reg.req_tgl;
        l_next.req_s2 = l_reg.req_s1;
        l_next.req_s3 = l_reg.req_s2;
        l_next.sda_s1 = pin_in.sda;
        l_next.sda_s2 = l_reg.sda_s1;
        l_next.sda_s3 = l_reg.sda_s2;
        l_next.scl_s1 = pin_in.scl;
        l_next.scl_s2 = l_reg.scl_s1;
        cnt_zero      = (l_reg.cnt == '0);

        // falling SDA while SCL high
        if (l_reg.scl_s2 && l_reg.sda_s3 && !l_reg.sda_s2) begin
            l_next.tg[TG_START] = ~l_reg.tg[TG_START];
        end

        case (l_reg.st)
            ST_IDLE: begin
                if (l_reg.req_s2 ^ l_reg.req_s3) begin
                    // baud value held still while busy
                    l_next.reload  = s_reg.baud;
                    l_next.scl_drv = 1'b1;
                    l_next.st      = ST_SCL_LOW;
                end
            end
            ST_SCL_LOW: begin
                if (!l_reg.scl_s2) begin
                    l_next.cnt = {{(BAUD_W-LOAD_W){1'b0}},
                                  l_reg.reload[LOAD_W-1:0]};
                    l_next.sda_drv = 1'b0;
                    l_next.st      = ST_SDA_REL;
                end
            end
            ST_SDA_REL: begin
                if (!cnt_zero) begin
                    l_next.cnt = l_reg.cnt - CNT_ONE;
                end else if (l_reg.sda_s2) begin
                    l_next.scl_drv = 1'b0;
                    l_next.st      = ST_SCL_REL;
                end else begin
                    // another party holds SDA low
                    l_next = collide(l_next);
                end
            end
            ST_SCL_REL: begin
                if (l_reg.scl_s2) begin
                    if (!l_reg.sda_s2) begin
                        l_next = collide(l_next);
                    end else begin
                        l_next.cnt = l_reg.reload;
                        l_next.st  = ST_HIGH_WAIT;
                    end
                end
            end
            ST_HIGH_WAIT: begin
                // SDA may fall here without harm
                if (!l_reg.scl_s2) begin
                    l_next = collide(l_next);
                end else if (!cnt_zero) begin
                    l_next.cnt = l_reg.cnt - CNT_ONE;
                end else begin
                    l_next.sda_drv = 1'b1;
                    l_next.cnt     = l_reg.reload;
                    l_next.st      = ST_SDA_LOW;
                end
            end
            ST_SDA_LOW: begin
                // SCL state no longer matters here
                if (!cnt_zero) begin
                    l_next.cnt = l_reg.cnt - CNT_ONE;
                end else begin
                    l_next.scl_drv = 1'b1;
                    l_next.tg[TG_DONE] = ~l_reg.tg[TG_DONE];
                    l_next.st = ST_IDLE;
                end
            end
            default: begin
                l_next.st = ST_IDLE;
            end
        endcase

        if (!l_reg.rst_s2) begin
            l_next        = '0;
            l_next.rst_s1 = resetn;
            l_next.rst_s2 = l_reg.rst_s1;
            l_next.st     = ST_IDLE;
        end
    end

    always_ff @(posedge link_clk) begin
        l_reg <= l_next;
    end

    assign pin_out = '{sda_o:  l_reg.lo,
                       sda_oe: l_reg.sda_drv,
                       scl_o:  l_reg.lo,
                       scl_oe: l_reg.scl_drv};

endmodule

// >>> sim/rsq_top_monitor.sv
// rsq_top_monitor: port assertions of the repeated start sequencer
// assumes: bound to rsq_top, pin enables seen on link_clk
module rsq_top_monitor
    import rsq_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  resetn,
    input wire logic                  link_clk,
    input wire rsq_pkg::rsq_av_req_t  av_req,
    input wire rsq_pkg::rsq_av_rsp_t  av_rsp,
    input wire logic                  other_event_busy,
    input wire rsq_pkg::rsq_pin_in_t  pin_in,
    input wire rsq_pkg::rsq_pin_out_t pin_out
);
    timeunit 1ns;
    timeprecision 100ps;
    chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
        (av_req.read || av_req.write) && av_rsp.waitrequest
        |=> !av_rsp.waitrequest) else $error("bus answer late");
    chk_answer_once: assert property (@(posedge sys_clk) disable iff (!resetn)
        !av_rsp.waitrequest |=> av_rsp.waitrequest)
        else $error("answer longer than one cycle");
    chk_upper_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        !av_rsp.waitrequest |-> av_rsp.readdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_write_data: assert property (@(posedge sys_clk) disable iff (!resetn)
        av_req.write && !av_rsp.waitrequest |-> av_rsp.readdata == WORD_ZERO)
        else $error("read data on write answer");
    chk_open_drain: assert property (@(posedge link_clk) disable iff (!resetn)
        !pin_out.sda_o && !pin_out.scl_o) else $error("pin driven high");
    chk_sda_release: assert property (
        @(posedge link_clk) disable iff (!resetn)
        $fell(pin_out.sda_oe) |-> pin_out.scl_oe)
        else $error("sda released while scl not held");
    chk_sda_drive: assert property (
        @(posedge link_clk) disable iff (!resetn)
        $rose(pin_out.sda_oe) |-> !pin_out.scl_oe
        ##[1:300] (pin_out.scl_oe && pin_out.sda_oe))
        else $error("sda drive not followed by scl low");
    chk_scl_release: assert property (
        @(posedge link_clk) disable iff (!resetn)
        $fell(pin_out.scl_oe) |-> !pin_out.sda_oe)
        else $error("scl released with sda held");
endmodule

bind rsq_top rsq_top_monitor rsq_top_monitor_inst (
    .sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
    .av_req(av_req), .av_rsp(av_rsp), .other_event_busy(other_event_busy),
    .pin_in(pin_in), .pin_out(pin_out));

// >>> sim/rsq_bus_model.sv
// rsq_bus_model: two-wire bus with pull-ups and a rival master
// assumes: holds come from the bench, enables from the device
module rsq_bus_model
    import rsq_pkg::*;
(
    input  wire rsq_pkg::rsq_pin_out_t pin_out,
    input  wire logic                  sda_hold,
    input  wire logic                  scl_hold,
    output      rsq_pkg::rsq_pin_in_t  pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // wired-and, released lines float high; rival master
    assign pin_in = '{sda: !(pin_out.sda_oe || sda_hold),
                      scl: !(pin_out.scl_oe || scl_hold)};
endmodule

// >>> sim/rsq_top_tb.sv
// rsq_top_tb: self-checking bench of the repeated start sequencer
// assumes: rsq_bus_model resolves the lines, Avalon master in tasks
module rsq_top_tb
    import rsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] S_EV = 32'h0000_0001 << ST_EVENT;
    localparam logic [31:0] S_WC = 32'h0000_0001 << ST_WRITE_COLLISION_FLAG;
    localparam logic [31:0] S_BC = 32'h0000_0001 << ST_BCOL;
    localparam logic [31:0] S_SD = 32'h0000_0001 << ST_START;
    localparam logic [31:0] S_BY = 32'h0000_0001 << ST_BUSY;
    logic         sys_clk = 0, link_clk = 0, resetn = 0;
    logic         other_event_busy = 0, sda_hold = 0, scl_hold = 0;
    rsq_av_req_t  av_req = '0;
    rsq_av_rsp_t  av_rsp;
    rsq_pin_in_t  pin_in;
    rsq_pin_out_t pin_out;
    logic [31:0]  q;
    logic [3:0]   be = 4'h1;
    int           failures = 0, cmp_count = 0, cycles = 0;

    rsq_top rsq_top_inst (.sys_clk(sys_clk), .resetn(resetn),
        .link_clk(link_clk), .av_req(av_req), .av_rsp(av_rsp),
        .other_event_busy(other_event_busy), .pin_in(pin_in),
        .pin_out(pin_out));
    rsq_bus_model rsq_bus_model_inst (.pin_out(pin_out),
        .sda_hold(sda_hold), .scl_hold(scl_hold), .pin_in(pin_in));

    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #2.3;
        forever #3 link_clk = ~link_clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        av_req.read <= !w;
        av_req.write <= w;
        av_req.address <= a;
        av_req.writedata <= d;
        av_req.byteenable <= be;
        do @(posedge sys_clk);
        while (av_rsp.waitrequest !== 1'b0);
        q = av_rsp.readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
    endtask

    task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                      input string nm);
        bus(1'b0, a, WORD_ZERO);
        chk(nm, e, q);
    endtask

    task automatic pins(input logic es, input logic ec);
        chk("sda_oe", {31'h0, es}, {31'h0, pin_out.sda_oe});
        chk("scl_oe", {31'h0, ec}, {31'h0, pin_out.scl_oe});
    endtask

    task automatic wait_idle();
        do bus(1'b0, OFS_STAT, WORD_ZERO);
        while (q[ST_BUSY] !== 1'b0);
    endtask

    task automatic t_reset();
        rc(OFS_BAUD, 32'h0000_0004, "baud reset");
        rc(4'h9, 32'h0000_0004, "baud low address bits");
        be = 4'h0;
        bus(1'b1, OFS_BAUD, 32'h0000_0033);
        be = 4'h1;
        rc(OFS_BAUD, 32'h0000_0004, "baud lane off");
        rc(OFS_SBUF, WORD_ZERO, "buffer reset");
        rc(OFS_STAT, WORD_ZERO, "status reset");
        rc(OFS_CTRL2, WORD_ZERO, "control reset");
        pins(1'b0, 1'b0);
    endtask

    task automatic t_restart();
        bus(1'b1, OFS_BAUD, 32'h0000_0008);
        bus(1'b1, OFS_SBUF, 32'h0000_005a);
        bus(1'b1, OFS_CTRL2, 32'h0000_0002);
        rc(OFS_STAT, S_BY, "status in sequence");
        bus(1'b1, OFS_SBUF, 32'h0000_00a5);
        bus(1'b1, OFS_CTRL2, 32'h0000_001d);
        bus(1'b1, OFS_BAUD, 32'h0000_0033);
        wait_idle();
        rc(OFS_STAT, S_EV | S_WC | S_SD, "status done");
        rc(OFS_CTRL2, WORD_ZERO, "control done");
        rc(OFS_SBUF, 32'h0000_005a, "buffer kept");
        rc(OFS_BAUD, 32'h0000_0008, "baud locked");
        pins(1'b1, 1'b1);
        bus(1'b1, OFS_SBUF, 32'h0000_003c);
        rc(OFS_SBUF, 32'h0000_003c, "buffer after event");
        bus(1'b1, OFS_STAT, 32'h0000_000f);
        rc(OFS_STAT, WORD_ZERO, "status cleared");
    endtask

    task automatic t_refuse();
        @(posedge sys_clk) other_event_busy <= 1'b1;
        bus(1'b1, OFS_CTRL2, 32'h0000_0002);
        rc(OFS_CTRL2, WORD_ZERO, "request refused");
        rc(OFS_STAT, WORD_ZERO, "no sequence");
        @(posedge sys_clk) other_event_busy <= 1'b0;
    endtask

    task automatic t_coll_sda();
        @(posedge sys_clk) sda_hold <= 1'b1;
        bus(1'b1, OFS_CTRL2, 32'h0000_0002);
        wait_idle();
        pins(1'b0, 1'b0);
        @(posedge sys_clk) sda_hold <= 1'b0;
        rc(OFS_STAT, S_EV | S_BC, "sda collision");
        bus(1'b1, OFS_STAT, 32'h0000_000f);
    endtask

    task automatic t_high_wait(input logic on_scl, input logic [31:0] e,
                               input logic p);
        bus(1'b1, OFS_BAUD, 32'h0000_0014);
        bus(1'b1, OFS_CTRL2, 32'h0000_0002);
        while (pin_out.scl_oe !== 1'b1) @(posedge sys_clk);
        while (pin_out.scl_oe !== 1'b0) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        if (on_scl)
            scl_hold <= 1'b1;
        else
            sda_hold <= 1'b1;
        wait_idle();
        pins(p, p);
        @(posedge sys_clk);
        scl_hold <= 1'b0;
        sda_hold <= 1'b0;
        rc(OFS_STAT, e, "status high wait");
        bus(1'b1, OFS_STAT, 32'h0000_000f);
    endtask

    // scl stretched by a rival, sda pulled low before scl is let go
    task automatic t_coll_rise();
        @(posedge sys_clk) scl_hold <= 1'b1;
        bus(1'b1, OFS_CTRL2, 32'h0000_0002);
        while (pin_out.scl_oe !== 1'b1) @(posedge sys_clk);
        while (pin_out.scl_oe !== 1'b0) @(posedge sys_clk);
        @(posedge sys_clk) sda_hold <= 1'b1;
        repeat (4) @(posedge sys_clk);
        scl_hold <= 1'b0;
        wait_idle();
        pins(1'b0, 1'b0);
        @(posedge sys_clk) sda_hold <= 1'b0;
        rc(OFS_STAT, S_EV | S_BC, "rise collision");
        bus(1'b1, OFS_STAT, 32'h0000_000f);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_restart();
        t_refuse();
        t_coll_sda();
        t_high_wait(1'b0, S_EV | S_SD, 1'b1);
        t_high_wait(1'b1, S_EV | S_BC, 1'b0);
        t_coll_rise();
        wrap_up();
    end
endmodule
